/* rtl/dct_chan.sv */
// One counter channel: 6-bit prescaler feeding an 8-bit down counter
module dct_chan
   import dct_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic enable,
   input wire logic src_pulse,
   input wire logic [5:0] ratio,
   input wire logic modulo,
   input wire logic [7:0] init_val,
   output logic [7:0] value,
   output logic eoc
);
   logic [6:0] pre_r;
   logic [7:0] cnt_r;
   logic eoc_r;
   logic [6:0] ratio_ext;
   logic tick;
   logic step;
   logic last;
   // ------------------------------------------------------------
   // Decode: ratio 00 stands for 64, count 00 for 256
   // ------------------------------------------------------------
   assign ratio_ext = (ratio == RST_RATIO) ? RATIO_FULL : {1'b0, ratio};
   // Single pass holds at 00 while the enable clear is still one cycle away
   assign step = enable & src_pulse & ~(eoc_r & ~modulo);
   assign tick = step & (pre_r <= 7'h01);
   assign last = (cnt_r == CNT_LAST);
   // Prescaler and counter; load restarts both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_r <= RATIO_FULL;
         cnt_r <= RST_BYTE;
         eoc_r <= 1'b0;
      end else begin
         eoc_r <= tick & last;
         if (load) begin
            pre_r <= ratio_ext;
            cnt_r <= init_val;
         end else if (step) begin
            pre_r <= tick ? ratio_ext : pre_r - 7'h01;
            if (tick) begin
               cnt_r <= (last & modulo) ? init_val : cnt_r - 8'h01;
            end
         end
      end
   end
   assign value = cnt_r;
   assign eoc = eoc_r;

   // Modulo mode reloads the initial value at end of count
   AST_MOD_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
      tick && last && modulo && !load |=> cnt_r == $past(init_val))
      else $error("modulo counter did not reload");
   // Each prescaler tick before the last count steps the counter down by one
   AST_DEC_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
      enable && src_pulse && tick && !last && !load |=> cnt_r == $past(cnt_r) - 8'h01)
      else $error("counter did not step on prescaler tick");
   COV_RELOAD: cover property (@(posedge aclk) tick && last && modulo);
endmodule // dct_chan

/* rtl/dct_edge.sv */
// Rising edge detector for the external count input
module dct_edge
   import dct_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_in,
   output logic rise
);
   logic prev_r;
   logic rise_r;
   // ------------------------------------------------------------
   // Edge capture; pin is synchronous so no extra stage
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         prev_r <= pin_in;
         rise_r <= pin_in & ~prev_r;
      end
   end
   assign rise = rise_r;
endmodule // dct_edge

/* rtl/dct_pkg.sv */
// Package: register map, field layout and reset values of the dual counter/timer
package dct_pkg;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [9:0] IDX_MODE = 10'h0F1;
   localparam logic [9:0] IDX_CNT1 = 10'h0F2;
   localparam logic [9:0] IDX_PRESCALER_ONE = 10'h0F3;
   localparam logic [9:0] IDX_CNT0 = 10'h0F4;
   localparam logic [9:0] IDX_PRE0 = 10'h0F5;
   localparam logic [9:0] IDX_STAT = 10'h100;
   localparam logic [9:0] IDX_MASK = 10'h101;
   localparam int ADDR_W = 12;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MODE_LOAD0 = 0;
   localparam int MODE_EN0 = 1;
   localparam int MODE_LOAD1 = 2;
   localparam int MODE_EN1 = 3;
   localparam int PRE_MODULO = 0;
   localparam int PRE_EXTSRC = 1;
   localparam int PRE_RATIO_LSB = 2;
   // ------------------------------------------------------------
   // Reset values and bus answers
   // ------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_RATIO = 6'h00;
   localparam logic [6:0] RATIO_FULL = 7'h40;
   localparam logic [7:0] CNT_LAST = 8'h01;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Register selector decoded from a bus address
   typedef enum logic [2:0] {
      REG_MODE, REG_CNT1, REG_PRESCALER_ONE, REG_CNT0, REG_PRE0, REG_STAT, REG_MASK, REG_NONE
   } dct_reg_t;
endpackage

/* rtl/dct_top.sv */
// Dual counter/timer with prescalers behind an AXI4-Lite slave
// Notes on behaviour
// - A timer mode register takes per counter a load command (reads as zero) and holds a readable count enable.
// - Counter one takes an initial value on write (01 is one count, 00 is 256) and reads back its live value.
// - Counter zero takes an initial value on write (00 is 256) and reads back its live value.
// - Prescaler one is write only with a 6-bit ratio (00 is 64) and a single pass or modulo bit.
// - Prescaler one has a source bit: 0 counts the internal clock, 1 counts external input edges.
// - Prescaler zero is write only with ratio, count mode and a reserved bit kept at zero.
module dct_top
   import dct_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_count_input,
   output logic irq
);
   // ------------------------------------------------------------
   // Address decode shared by the read and write paths
   // ------------------------------------------------------------
   function automatic dct_reg_t reg_sel(input logic [ADDR_W-1:0] a);
      dct_reg_t r;
      r = REG_NONE;
      if (a[1:0] == 2'h0) begin
         case (a[ADDR_W-1:2])
            IDX_MODE: r = REG_MODE;
            IDX_CNT1: r = REG_CNT1;
            IDX_PRESCALER_ONE: r = REG_PRESCALER_ONE;
            IDX_CNT0: r = REG_CNT0;
            IDX_PRE0: r = REG_PRE0;
            IDX_STAT: r = REG_STAT;
            IDX_MASK: r = REG_MASK;
            default: r = REG_NONE;
         endcase
      end
      return r;
   endfunction

   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic aw_held_r;
   logic w_held_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic en0_r;
   logic en1_r;
   logic [7:0] init0_r;
   logic [7:0] init1_r;
   logic [7:0] pre0_r;
   logic [7:0] prescaler_one_r;
   logic [1:0] stat_r;
   logic [1:0] mask_r;
   logic irq_r;
   logic [1:0] stat_nxt;
   logic en0_nxt;
   logic en1_nxt;
   logic [1:0] mask_nxt;

   // ------------------------------------------------------------
   // Handshake and strobe decode
   // ------------------------------------------------------------
   logic aw_hs;
   logic w_hs;
   logic b_hs;
   logic ar_hs;
   logic r_hs;
   logic do_wr;
   logic wr_ok;
   dct_reg_t wsel;
   dct_reg_t rsel;
   logic wr_mode;
   logic load0;
   logic load1;
   logic ext_rise;
   logic src1;
   logic eoc0;
   logic eoc1;
   logic [7:0] cnt0_val;
   logic [7:0] cnt1_val;
   logic [31:0] rd_mux;

   assign aw_hs = s_axi_awvalid & awready_r;
   assign w_hs = s_axi_wvalid & wready_r;
   assign b_hs = bvalid_r & s_axi_bready;
   assign ar_hs = s_axi_arvalid & arready_r;
   assign r_hs = rvalid_r & s_axi_rready;
   // Write lands once both halves are held and no response is pending
   assign do_wr = aw_held_r & w_held_r & ~bvalid_r;
   assign wsel = reg_sel(waddr_r);
   assign rsel = reg_sel(s_axi_araddr);
   // Only byte lane 0 carries register data
   assign wr_ok = do_wr & wlane_r;
   assign wr_mode = wr_ok & (wsel == REG_MODE);
   assign load0 = wr_mode & wbyte_r[MODE_LOAD0];
   assign load1 = wr_mode & wbyte_r[MODE_LOAD1];

   // ------------------------------------------------------------
   // Write channel capture, either order of address and data
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= '0;
         wbyte_r <= RST_BYTE;
         wlane_r <= 1'b0;
      end else begin
         if (aw_hs) begin
            waddr_r <= s_axi_awaddr;
         end
         if (w_hs) begin
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
         end
         aw_held_r <= aw_hs | (aw_held_r & ~do_wr);
         w_held_r <= w_hs | (w_held_r & ~do_wr);
         awready_r <= b_hs | (awready_r & ~aw_hs);
         wready_r <= b_hs | (wready_r & ~w_hs);
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (b_hs) begin
         bvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   // Software set of an enable wins over the single pass stop
   // The stop lags end of count by a cycle; the channel idles meanwhile
   always_comb begin
      en0_nxt = en0_r & ~(eoc0 & ~pre0_r[PRE_MODULO]);
      en1_nxt = en1_r & ~(eoc1 & ~prescaler_one_r[PRE_MODULO]);
      if (wr_mode) begin
         en0_nxt = wbyte_r[MODE_EN0];
         en1_nxt = wbyte_r[MODE_EN1];
      end
   end

   // Sticky end-of-count flags, set wins over write-one-to-clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr_ok & (wsel == REG_STAT)) begin
         stat_nxt = stat_r & ~wbyte_r[1:0];
      end
      stat_nxt = stat_nxt | {eoc1, eoc0};
   end

   // Enables, sticky flags and the registered interrupt level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en0_r <= 1'b0;
         en1_r <= 1'b0;
         stat_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         en0_r <= en0_nxt;
         en1_r <= en1_nxt;
         stat_r <= stat_nxt;
         irq_r <= |(stat_nxt & mask_nxt);
      end
   end

   // Mask as seen in the same cycle, so irq follows a mask write at once
   assign mask_nxt = (wr_ok & (wsel == REG_MASK)) ? wbyte_r[1:0] : mask_r;

   // Initial values, prescaler settings and mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         init0_r <= RST_BYTE;
         init1_r <= RST_BYTE;
         pre0_r <= RST_BYTE;
         prescaler_one_r <= RST_BYTE;
         mask_r <= 2'h0;
      end else if (wr_ok) begin
         case (wsel)
            REG_CNT1: init1_r <= wbyte_r;
            REG_CNT0: init0_r <= wbyte_r;
            REG_PRESCALER_ONE: prescaler_one_r <= wbyte_r;
            REG_PRE0: pre0_r <= {wbyte_r[7:2], 1'b0, wbyte_r[0]};
            REG_MASK: mask_r <= wbyte_r[1:0];
            default: mask_r <= mask_r;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Counter channels
   // ------------------------------------------------------------
   dct_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(external_count_input),
      .rise(ext_rise)
   );
   // Channel one source: internal clock or external edges
   assign src1 = prescaler_one_r[PRE_EXTSRC] ? ext_rise : 1'b1;

   dct_chan u_chan0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load0),
      .enable(en0_r),
      .src_pulse(1'b1),
      .ratio(pre0_r[7:PRE_RATIO_LSB]),
      .modulo(pre0_r[PRE_MODULO]),
      .init_val(init0_r),
      .value(cnt0_val),
      .eoc(eoc0)
   );
   dct_chan u_chan1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(load1),
      .enable(en1_r),
      .src_pulse(src1),
      .ratio(prescaler_one_r[7:PRE_RATIO_LSB]),
      .modulo(prescaler_one_r[PRE_MODULO]),
      .init_val(init1_r),
      .value(cnt1_val),
      .eoc(eoc1)
   );

   // ------------------------------------------------------------
   // Read path; write-only prescalers read as zero
   // ------------------------------------------------------------
   assign rd_mux = (rsel == REG_MODE) ? {28'h0, en1_r, 1'b0, en0_r, 1'b0} :
                   (rsel == REG_CNT1) ? {24'h0, cnt1_val} :
                   (rsel == REG_CNT0) ? {24'h0, cnt0_val} :
                   (rsel == REG_STAT) ? {30'h0, stat_r} :
                   (rsel == REG_MASK) ? {30'h0, mask_r} : 32'h0;

   // One read at a time: arready stays low until the data is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= (rsel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (r_hs) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign irq = irq_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   AST_LOAD_START: assert property (@(posedge aclk) disable iff (!aresetn)
      load0 |=> cnt0_val == $past(init0_r) && en0_r == $past(wbyte_r[MODE_EN0]))
      else $error("load or enable of counter zero not applied");
   AST_RD_CNT1: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rsel == REG_CNT1 |=> rdata_r == {24'h0, $past(cnt1_val)})
      else $error("counter one read is not the live value");
   AST_RD_CNT0: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rsel == REG_CNT0 |=> rdata_r == {24'h0, $past(cnt0_val)})
      else $error("counter zero read is not the live value");
   AST_PRESCALER_ONE_WO: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_hs && rsel == REG_PRESCALER_ONE |=> rdata_r == 32'h0 && rresp_r == RESP_OKAY)
      else $error("prescaler one did not read as zero");
   AST_EXT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      en1_r && prescaler_one_r[PRE_EXTSRC] && !ext_rise && !load1 |=> $stable(cnt1_val))
      else $error("counter one moved without an external edge");
   AST_PRE0_RSVD: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ok && wsel == REG_PRE0 |=> pre0_r[PRE_EXTSRC] == 1'b0)
      else $error("reserved prescaler zero bit stored as one");
   // Single pass parks at 00 with its enable cleared
   AST_SINGLE_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
      eoc0 && !pre0_r[PRE_MODULO] && !wr_mode |=> !en0_r && cnt0_val == 8'h00 ##1 $stable(cnt0_val))
      else $error("single pass counter zero kept running");
   AST_STOP_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
      eoc1 && !prescaler_one_r[PRE_MODULO] && !wr_mode |=> !en1_r && cnt1_val == 8'h00)
      else $error("single pass counter one kept running");
   AST_IRQ_RAISE: assert property (@(posedge aclk) disable iff (!aresetn)
      eoc1 && mask_nxt[1] |=> stat_r[1] && irq_r)
      else $error("end of count did not raise the interrupt");
   AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_r == |(stat_r & mask_r))
      else $error("interrupt level does not match unmasked flags");
   // One write and one read at a time; unmapped writes answer an error
   AST_AW_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid_r |-> !awready_r && !wready_r)
      else $error("write channel ready while a response is pending");
   AST_AR_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_r |-> !arready_r)
      else $error("read address ready while read data is pending");
   AST_WR_SLVERR: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr && wsel == REG_NONE |=> bvalid_r && bresp_r == RESP_SLVERR)
      else $error("unmapped write did not answer an error");
   COV_WRITE: cover property (@(posedge aclk) do_wr && wsel == REG_MODE);
   COV_EXT: cover property (@(posedge aclk) eoc1 && prescaler_one_r[PRE_EXTSRC]);
   COV_IRQ: cover property (@(posedge aclk) irq_r ##1 !irq_r);
   COV_STOP: cover property (@(posedge aclk) eoc0 && !pre0_r[PRE_MODULO]);
endmodule // dct_top

/* tb/testbench.sv */
// Self-checking bench for the dual counter/timer behind its AXI4-Lite slave
module testbench
   import dct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals, addresses and bookkeeping
   // ------------------------------------------------------------
   localparam logic [11:0] A_MODE = {IDX_MODE, 2'b00};
   localparam logic [11:0] A_CNT1 = {IDX_CNT1, 2'b00};
   localparam logic [11:0] A_PRESCALER_ONE = {IDX_PRESCALER_ONE, 2'b00};
   localparam logic [11:0] A_CNT0 = {IDX_CNT0, 2'b00};
   localparam logic [11:0] A_PRE0 = {IDX_PRE0, 2'b00};
   localparam logic [11:0] A_STAT = {IDX_STAT, 2'b00};
   localparam logic [11:0] A_MASK = {IDX_MASK, 2'b00};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] s_axi_awaddr = '0;
   logic [ADDR_W-1:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp;
   logic [1:0] s_axi_rresp;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic external_count_input = 1'b0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [15:0] lfsr = 16'hEE0B; // Seed 60939
   logic [7:0] v;
   int errors = 0;
   int checks_done = 0;

   // 100 MHz core clock
   initial begin
      forever #5 aclk = ~aclk;
   end

   dct_top dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .external_count_input(external_count_input), .irq(irq)
   );

   // ------------------------------------------------------------
   // Comparison and reporting
   // ------------------------------------------------------------
   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
      chk(e, g);
   endtask
   task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
      chk({32'h0, e}, {32'h0, g});
   endtask
   // Two edges let the status update and the registered irq land
   task automatic cmp_irq(input logic e);
      repeat (2) @(posedge aclk);
      chk({33'h0, e}, {33'h0, irq});
   endtask
   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask
   task automatic finish_test();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Monitor: each answer on the bus retires the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         cmp_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
         cmp_wr(bq.pop_front(), s_axi_bresp);
      end
   end

   // ------------------------------------------------------------
   // Bus master tasks
   // ------------------------------------------------------------
   // Valid and payload held until each channel's own ready edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      bq.push_back(er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      rq.push_back({er, 24'h0, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // One rising edge on the external count pin, well apart from the next
   task automatic pulse();
      @(posedge aclk);
      external_count_input <= 1'b1;
      repeat (5) @(posedge aclk);
      external_count_input <= 1'b0;
      repeat (5) @(posedge aclk);
   endtask
   // Counter zero in single pass: no end of count early, end of count late
   task automatic span(input logic [7:0] pre, input logic [7:0] init, input int early, input int late);
      wr(A_STAT, 8'h03);
      wr(A_PRE0, pre);
      wr(A_CNT0, init);
      wr(A_MODE, 8'h03);
      repeat (early) @(posedge aclk);
      rd(A_STAT, 8'h00);
      repeat (late) @(posedge aclk);
      rd(A_STAT, 8'h01);
   endtask
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
   endfunction

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      cmp_irq(1'b0);
      rd(A_MODE, 8'h00);
      rd(A_CNT1, 8'h00);
      rd(A_PRESCALER_ONE, 8'h00);
      rd(A_CNT0, 8'h00);
      rd(A_PRE0, 8'h00);
      rd(A_STAT, 8'h00);
      rd(A_MASK, 8'h00);
      end_test("reset");
      // Unmapped and misaligned places answer an error and change nothing
      rd(12'h008, 8'h00, RESP_SLVERR);
      wr(12'h008, 8'hFF, RESP_SLVERR);
      wr(12'h3C6, 8'h0F, RESP_SLVERR);
      rd(12'h3C5, 8'h00, RESP_SLVERR);
      rd(A_MODE, 8'h00);
      end_test("unmapped");
      // Load stopped counters; a later initial value must not show on read
      for (int i = 0; i < 4; i++) begin
         v = lfsr[7:0];
         lfsr = lfsr_next(lfsr);
         wr(A_CNT0, v);
         wr(A_CNT1, ~v);
         wr(A_MODE, 8'h05);
         rd(A_MODE, 8'h00);
         rd(A_CNT0, v);
         rd(A_CNT1, ~v);
         wr(A_CNT0, v + 8'h01);
         wr(A_CNT1, v + 8'h01);
         rd(A_CNT0, v);
         rd(A_CNT1, ~v);
      end
      end_test("load");
      // Enables read back; longest counts keep both running meanwhile
      wr(A_PRE0, 8'h00);
      wr(A_PRESCALER_ONE, 8'h00);
      wr(A_CNT0, 8'h00);
      wr(A_CNT1, 8'h00);
      wr(A_MODE, 8'h0F);
      rd(A_MODE, 8'h0A);
      rd(A_PRESCALER_ONE, 8'h00);
      wr(A_MODE, 8'h00);
      rd(A_MODE, 8'h00);
      end_test("enable");
      // Single pass with the reserved bit set, then mask and clear the flag
      wr(A_STAT, 8'h03);
      wr(A_PRE0, 8'h06);
      wr(A_CNT0, 8'h03);
      wr(A_MODE, 8'h03);
      repeat (20) @(posedge aclk);
      rd(A_CNT0, 8'h00);
      rd(A_MODE, 8'h00);
      rd(A_STAT, 8'h01);
      cmp_irq(1'b0);
      wr(A_MASK, 8'h02);
      cmp_irq(1'b0);
      wr(A_MASK, 8'h01);
      cmp_irq(1'b1);
      wr(A_STAT, 8'h01);
      cmp_irq(1'b0);
      end_test("single");
      // Modulo on counter one keeps reloading and flagging
      wr(A_PRESCALER_ONE, 8'h05);
      wr(A_CNT1, 8'h04);
      wr(A_STAT, 8'h03);
      wr(A_MASK, 8'h02);
      wr(A_MODE, 8'h0C);
      repeat (20) @(posedge aclk);
      rd(A_STAT, 8'h02);
      wr(A_STAT, 8'h02);
      repeat (20) @(posedge aclk);
      rd(A_STAT, 8'h02);
      cmp_irq(1'b1);
      rd(A_MODE, 8'h08);
      wr(A_MODE, 8'h00);
      end_test("modulo");
      // External pin clocks counter one; the core clock must not
      wr(A_STAT, 8'h03);
      wr(A_PRESCALER_ONE, 8'h06);
      wr(A_CNT1, 8'h03);
      wr(A_MODE, 8'h0C);
      repeat (30) @(posedge aclk);
      rd(A_CNT1, 8'h03);
      pulse();
      pulse();
      rd(A_CNT1, 8'h01);
      pulse();
      rd(A_CNT1, 8'h00);
      rd(A_STAT, 8'h02);
      wr(A_STAT, 8'h03);
      cmp_irq(1'b0);
      end_test("external");
      // Boundary codes: ratio 00 is 64, initial 00 is 256
      span(8'h00, 8'h01, 30, 60);
      span(8'h04, 8'h00, 200, 100);
      end_test("boundary");
      finish_test();
   end

   // Whole run needs about a thousand cycles
   initial begin
      repeat (30000) @(posedge aclk);
      errors++;
      finish_test();
   end
endmodule // testbench
